// *** verilog/ptc_capture.sv ***
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ptc_capture #(
	parameter int DEPTH = ptc_pkg::FIFO_DEPTH,
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [63:0] system_time,
	input wire logic frame_valid,
	input wire logic frame_is_tx,
	input wire logic frame_is_sync,
	input wire logic frame_is_delay_req,
	input wire logic [7:0] frame_sub_domain,
	input wire logic [63:0] rx_source_identity,
	input wire logic [15:0] rx_sequence_number_field,
	output logic irq
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int ENT_W = ptc_pkg::ENT_W;
	localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(DEPTH);

	// ==========================================================
	// parameter checks
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("fifo depth must be a power of two of at least 2");
		end
		if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
			$error("address width must lie between 10 and 32");
		end
	endgenerate

	// ==========================================================
	// state
	typedef struct packed {
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [63:0] tx_stamp;
		logic tx_flag;
		logic [7:0] sub_domain;
		logic [1:0] mask;
		logic master;
		logic [DEPTH-1:0][ENT_W-1:0] mem;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [PTR_W:0] count;
	} ptc_state_t;

	ptc_state_t q;
	ptc_state_t d;

	logic match;
	logic tx_time_capture;
	logic rx_event;
	logic rx_time_capture;
	logic pop;
	logic full;
	logic rx_pending;
	logic [ENT_W-1:0] head;
	logic [63:0] head_stamp;
	logic [63:0] head_src;
	logic [15:0] head_seq;
	logic [ptc_pkg::REG_IDX_W-1:0] wr_idx;
	logic [ptc_pkg::REG_IDX_W-1:0] rd_idx;
	logic wr_ok;
	logic rd_ok;
	logic [15:0] rword;
	logic [ptc_pkg::EVT_W-1:0] status;

	// ==========================================================
	// frame qualification
	// frame path signals come from switch logic on aclk, no sync needed
	assign match = frame_valid
		&& (frame_sub_domain == q.sub_domain);
	assign tx_time_capture = match && frame_is_tx && !q.tx_flag
		&& (q.master ? frame_is_sync : frame_is_delay_req);
	assign rx_event = match && !frame_is_tx
		&& (q.master ? frame_is_delay_req : frame_is_sync);
	// a pop in the same cycle does not make room: simpler, one entry lost
	assign full = (q.count == DEPTH_C);
	assign rx_time_capture = rx_event && !full;
	assign rx_pending = (q.count != '0);

	assign head = q.mem[q.rd_ptr];
	assign head_stamp = head[ptc_pkg::ENT_STAMP_LSB +: ptc_pkg::STAMP_W];
	assign head_src = head[ptc_pkg::ENT_SRC_LSB +: ptc_pkg::STAMP_W];
	assign head_seq = head[ptc_pkg::ENT_SEQ_LSB +: ptc_pkg::SEQ_W];

	assign status[ptc_pkg::EVT_TX_BIT] = q.tx_flag;
	assign status[ptc_pkg::EVT_RX_BIT] = rx_pending;

	// ==========================================================
	// address decode
	assign wr_idx = q.aw_addr[8:2];
	assign wr_ok = (q.aw_addr[ADDR_W-1:9] == '0)
		&& (q.aw_addr[1:0] == 2'h0);
	assign rd_idx = s_axi_araddr[8:2];
	assign rd_ok = (s_axi_araddr[ADDR_W-1:9] == '0)
		&& (s_axi_araddr[1:0] == 2'h0);

	// ==========================================================
	// next state
	always_comb begin
		d = q;
		pop = 1'b0;
		rword = 16'h0000;

		// write address and data taken in either order
		if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
			d.aw_got = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
			d.w_got = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_got && q.w_got) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = ptc_pkg::RESP_OKAY;
			if (!wr_ok) begin
				d.bresp = ptc_pkg::RESP_SLVERR;
			end else begin
				case (wr_idx)
				ptc_pkg::IDX_SUBDOMAIN: begin
					if (q.w_strb[0]) begin
						d.sub_domain = q.w_data[7:0];
					end
				end
				ptc_pkg::IDX_EVENT: begin
					if (q.w_strb[0]
						&& q.w_data[ptc_pkg::EVT_TX_BIT]) begin
						d.tx_flag = 1'b0;
					end
					// acknowledge releases the head entry
					if (q.w_strb[0]
						&& q.w_data[ptc_pkg::EVT_RX_BIT]) begin
						pop = rx_pending;
					end
				end
				ptc_pkg::IDX_MASK: begin
					if (q.w_strb[0]) begin
						d.mask = q.w_data[ptc_pkg::EVT_W-1:0];
					end
				end
				ptc_pkg::IDX_CTRL: begin
					if (q.w_strb[0]) begin
						d.master = q.w_data[ptc_pkg::CTRL_MASTER_BIT];
					end
				end
				ptc_pkg::IDX_TX_W0, ptc_pkg::IDX_TX_W1,
				ptc_pkg::IDX_TX_W2, ptc_pkg::IDX_TX_W3,
				ptc_pkg::IDX_RX_W0, ptc_pkg::IDX_RX_W1,
				ptc_pkg::IDX_RX_W2, ptc_pkg::IDX_RX_W3,
				ptc_pkg::IDX_SRC_W0, ptc_pkg::IDX_SRC_W1,
				ptc_pkg::IDX_SRC_W2, ptc_pkg::IDX_SRC_W3,
				ptc_pkg::IDX_SEQ: begin
					d.bresp = ptc_pkg::RESP_OKAY;
				end
				default: begin
					d.bresp = ptc_pkg::RESP_SLVERR;
				end
				endcase
			end
		end

		// read: registered data one cycle after the address
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp = ptc_pkg::RESP_OKAY;
			// words stay still until acknowledged, so any order works
			case (rd_idx)
			ptc_pkg::IDX_TX_W0: rword = q.tx_stamp[15:0];
			ptc_pkg::IDX_TX_W1: rword = q.tx_stamp[31:16];
			ptc_pkg::IDX_TX_W2: rword = q.tx_stamp[47:32];
			ptc_pkg::IDX_TX_W3: rword = q.tx_stamp[63:48];
			ptc_pkg::IDX_RX_W0: rword = head_stamp[15:0];
			ptc_pkg::IDX_RX_W1: rword = head_stamp[31:16];
			ptc_pkg::IDX_RX_W2: rword = head_stamp[47:32];
			ptc_pkg::IDX_RX_W3: rword = head_stamp[63:48];
			ptc_pkg::IDX_SRC_W0: rword = head_src[15:0];
			ptc_pkg::IDX_SRC_W1: rword = head_src[31:16];
			ptc_pkg::IDX_SRC_W2: rword = head_src[47:32];
			ptc_pkg::IDX_SRC_W3: rword = head_src[63:48];
			ptc_pkg::IDX_SEQ: rword = head_seq;
			ptc_pkg::IDX_SUBDOMAIN: begin
				rword = {8'h00, q.sub_domain};
			end
			ptc_pkg::IDX_EVENT: rword = {14'h0000, status};
			ptc_pkg::IDX_MASK: rword = {14'h0000, q.mask};
			ptc_pkg::IDX_CTRL: rword = {15'h0000, q.master};
			default: d.rresp = ptc_pkg::RESP_SLVERR;
			endcase
			if (!rd_ok) begin
				rword = 16'h0000;
				d.rresp = ptc_pkg::RESP_SLVERR;
			end
			d.rdata = {16'h0000, rword};
		end

		// capture after the clear, so a set would win
		if (tx_time_capture) begin
			d.tx_stamp = system_time;
			d.tx_flag = 1'b1;
		end

		// receive fifo
		if (rx_time_capture) begin
			d.mem[q.wr_ptr] = {rx_sequence_number_field,
				rx_source_identity,
				system_time};
			d.wr_ptr = PTR_W'(q.wr_ptr + 1'b1);
		end
		if (pop) begin
			d.rd_ptr = PTR_W'(q.rd_ptr + 1'b1);
		end
		case ({rx_time_capture, pop})
		2'b10: d.count = (PTR_W+1)'(q.count + 1'b1);
		2'b01: d.count = (PTR_W+1)'(q.count - 1'b1);
		default: d.count = q.count;
		endcase

		if (!aresetn) begin
			d = '0;
			d.sub_domain = ptc_pkg::RST_SUBDOMAIN;
			d.mask = ptc_pkg::RST_MASK;
			d.master = ptc_pkg::RST_MASTER;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn || clk_en) begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready = !q.aw_got && !q.bvalid;
	assign s_axi_wready = !q.w_got && !q.bvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign irq = |(status & q.mask);

endmodule

// *** verilog/ptc_pkg.sv ***
// What this block does
// - tx Sync as master or Delay_Req as slave latches system time
// - each transmit capture sets the transmit-capture event flag
// - write one clears transmit flag; no new capture while it is set
// - rx Sync as slave or Delay_Req as master takes a timestamp
// - receive-capture flag is set while a receive entry is waiting
// - the four 16-bit words of a snapshot read alike in any order
// - receive entries wait in a sixteen-entry fifo
// - with the fifo full, qualifying frames are dropped, entries kept
// - receive flag stays set while entries remain, clears when empty
// - each receive entry holds the frame's 64-bit source identity
// - each receive entry holds the frame's 16-bit sequence number
// - only frames whose sub-domain matches the programmed value count
package ptc_pkg;

	// ==========================================================
	// register indices, byte address is four times the index
	localparam int REG_IDX_W = 7;
	localparam logic [6:0] IDX_TX_W0 = 7'h34;
	localparam logic [6:0] IDX_TX_W1 = 7'h36;
	localparam logic [6:0] IDX_TX_W2 = 7'h38;
	localparam logic [6:0] IDX_TX_W3 = 7'h3a;
	localparam logic [6:0] IDX_RX_W0 = 7'h3c;
	localparam logic [6:0] IDX_RX_W1 = 7'h3e;
	localparam logic [6:0] IDX_RX_W2 = 7'h40;
	localparam logic [6:0] IDX_RX_W3 = 7'h42;
	localparam logic [6:0] IDX_SRC_W0 = 7'h44;
	localparam logic [6:0] IDX_SRC_W1 = 7'h46;
	localparam logic [6:0] IDX_SRC_W2 = 7'h48;
	localparam logic [6:0] IDX_SRC_W3 = 7'h4a;
	localparam logic [6:0] IDX_SEQ = 7'h4c;
	localparam logic [6:0] IDX_SUBDOMAIN = 7'h4e;
	localparam logic [6:0] IDX_EVENT = 7'h58;
	localparam logic [6:0] IDX_MASK = 7'h5a;
	localparam logic [6:0] IDX_CTRL = 7'h5c;

	// ==========================================================
	// field positions
	localparam int EVT_TX_BIT = 0;
	localparam int EVT_RX_BIT = 1;
	localparam int EVT_W = 2;
	localparam int CTRL_MASTER_BIT = 0;
	localparam int SUB_W = 8;
	localparam int STAMP_W = 64;
	localparam int SEQ_W = 16;
	localparam int ENT_STAMP_LSB = 0;
	localparam int ENT_SRC_LSB = 64;
	localparam int ENT_SEQ_LSB = 128;
	localparam int ENT_W = 144;

	// ==========================================================
	// reset values and defaults
	localparam logic [7:0] RST_SUBDOMAIN = 8'h00;
	localparam logic [1:0] RST_MASK = 2'h0;
	localparam logic RST_MASTER = 1'b0;
	localparam int FIFO_DEPTH = 16;

	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** verification/ptc_capture_assertions.sv ***
`timescale 1ns/1ps
module ptc_capture_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq
);
	// ==========================================
	// bus timing
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wr_ans; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
	property p_rd_ans; s_rd |=> s_axi_rvalid; endproperty
	property p_b_end; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	property p_r_end; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_aw_blk;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_hi_zero; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0; endproperty
	property p_err_data;
		s_axi_rvalid && s_axi_rresp == ptc_pkg::RESP_SLVERR |-> s_axi_rdata == 0;
	endproperty
	// reset itself is the cause here, so it cannot disable
	property p_reset;
		disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
	a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
	a_b_end: assert property (p_b_end) else $error("bvalid stuck");
	a_r_end: assert property (p_r_end) else $error("rvalid stuck");
	a_ar_blk: assert property (p_ar_blk) else $error("arready early");
	a_aw_blk: assert property (p_aw_blk) else $error("awready early");
	a_hi_zero: assert property (p_hi_zero) else $error("upper half set");
	a_err_data: assert property (p_err_data) else $error("error data");
	a_reset: assert property (p_reset) else $error("reset state");
endmodule
bind ptc_capture ptc_capture_checker u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// *** verification/ptc_port_model.sv ***
`timescale 1ns/1ps
module ptc_port_model (
	input wire logic aclk,
	output logic [63:0] st,
	output logic fv,
	output logic ftx,
	output logic fs,
	output logic fd,
	output logic [7:0] fsd,
	output logic [63:0] fid,
	output logic [15:0] fsq
);
	// ==========================================
	// one frame pulse, fields scrambled when idle
	initial {st, fv, ftx, fs, fd, fsd, fid, fsq} = '0;
	task automatic send(input logic t, s, d, input logic [7:0] sd,
		input logic [63:0] ti, id, input logic [15:0] q);
		@(posedge aclk);
		{fv, ftx, fs, fd, fsd, st, fid, fsq} <= {1'b1, t, s, d, sd, ti, id, q};
		@(posedge aclk);
		// idle fields must not look valid to the capture logic
		{fv, ftx, fs, fd, fsd, st, fid, fsq} <= {1'b0, ~t, ~s, ~d, ~sd, ~ti, ~id, ~q};
	endtask
endmodule

// *** verification/ptp_frame_timestamp_capture_tb_top.sv ***
`timescale 1ns/1ps
module ptp_frame_timestamp_capture_tb_top;
	// ==========================================
	// stimulus and checks
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid, irq;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, lf = 32'h47, d;
	logic [1:0] bresp, rresp, r;
	logic [63:0] st, fid, ts[17], id[17];
	logic [15:0] fsq, sq[17];
	logic [7:0] fsd;
	logic fv, ftx, fs, fd;
	int err_count = 0, n_compared = 0;
	always #4 aclk = ~aclk;
	ptc_port_model pm (.aclk(aclk), .st(st), .fv(fv), .ftx(ftx), .fs(fs),
		.fd(fd), .fsd(fsd), .fid(fid), .fsq(fsq));
	ptc_capture dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .system_time(st), .frame_valid(fv),
		.frame_is_tx(ftx), .frame_is_sync(fs), .frame_is_delay_req(fd),
		.frame_sub_domain(fsd), .rx_source_identity(fid),
		.rx_sequence_number_field(fsq), .irq(irq));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task finish_test;
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task to(input int n);
		if (n >= 50) begin
			err_count++;
			$display("CHECK FAILED handshake exp done got timeout");
			finish_test;
		end
	endtask
	// bready held from the start so a sampled bvalid is the handshake
	task wr(input logic [6:0] i, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {3'h0, i, 2'h0, v, 3'h7};
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		to(n);
		chk("bresp", {30'h0, ptc_pkg::RESP_OKAY}, {30'h0, bresp});
	endtask
	task rd(input logic [6:0] i, output logic [31:0] v, output logic [1:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		{araddr, arvalid, rready} <= {3'h0, i, 2'h0, 2'h3};
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		{v, e} = {rdata, rresp};
		rready <= 1'b0;
		to(n);
	endtask
	task rc(input string nm, input logic [6:0] i, input logic [31:0] e);
		rd(i, d, r);
		chk(nm, e, d);
	endtask
	// words taken out of order on purpose
	task r64(input string nm, input logic [6:0] b, input logic [63:0] e);
		rc(nm, b + 7'h6, {16'h0, e[63:48]});
		rc(nm, b, {16'h0, e[15:0]});
		rc(nm, b + 7'h4, {16'h0, e[47:32]});
		rc(nm, b + 7'h2, {16'h0, e[31:16]});
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		r64("tx", ptc_pkg::IDX_TX_W0, 0);
		r64("rx", ptc_pkg::IDX_RX_W0, 0);
		rc("seq", ptc_pkg::IDX_SEQ, 0);
		rd(7'h01, d, r);
		chk("slverr", {30'h0, ptc_pkg::RESP_SLVERR}, {30'h0, r});
		wr(ptc_pkg::IDX_MASK, 32'h3);
		pm.send(1, 1, 0, 0, 64'h11, 0, 0);
		rc("evt", ptc_pkg::IDX_EVENT, 0);
		pm.send(1, 0, 1, 0, 64'h1122334455667788, 0, 0);
		pm.send(1, 0, 1, 0, 64'h99, 0, 0);
		rc("evt", ptc_pkg::IDX_EVENT, 1);
		chk("irq", 1, {31'h0, irq});
		r64("tx", ptc_pkg::IDX_TX_W0, 64'h1122334455667788);
		wr(ptc_pkg::IDX_EVENT, 1);
		chk("irq", 0, {31'h0, irq});
		pm.send(1, 0, 1, 0, 64'h99, 0, 0);
		r64("tx", ptc_pkg::IDX_TX_W0, 64'h99);
		wr(ptc_pkg::IDX_EVENT, 1);
		pm.send(0, 1, 0, 8'h05, 64'h5, 0, 0);
		rc("evt", ptc_pkg::IDX_EVENT, 0);
		wr(ptc_pkg::IDX_SUBDOMAIN, 32'h5);
		for (int k = 0; k < 17; k++) begin
			lf = nx(lf);
			ts[k] = {lf, ~lf};
			lf = nx(lf);
			{id[k], sq[k]} = {~lf, lf, lf[31:16]};
			pm.send(0, 1, 0, 8'h05, ts[k], id[k], sq[k]);
		end
		for (int k = 0; k < 16; k++) begin
			rc("evt", ptc_pkg::IDX_EVENT, 2);
			r64("rxts", ptc_pkg::IDX_RX_W0, ts[k]);
			r64("src", ptc_pkg::IDX_SRC_W0, id[k]);
			rc("seq", ptc_pkg::IDX_SEQ, {16'h0, sq[k]});
			wr(ptc_pkg::IDX_EVENT, 2);
		end
		rc("evt", ptc_pkg::IDX_EVENT, 0);
		chk("irq", 0, {31'h0, irq});
		wr(ptc_pkg::IDX_CTRL, 1);
		pm.send(0, 0, 1, 8'h05, 64'h77, 64'h3, 16'h4);
		pm.send(1, 1, 0, 8'h05, 64'h88, 0, 0);
		rc("evt", ptc_pkg::IDX_EVENT, 3);
		r64("tx", ptc_pkg::IDX_TX_W0, 64'h88);
		r64("rxts", ptc_pkg::IDX_RX_W0, 64'h77);
		finish_test;
	end
endmodule
